// ---- clock_fanout_host.sv ----
// host end: axi4-lite driven master that writes the fan-out configuration
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module clock_fanout_host
    import clk_fanout_pkg::*;
#(
    parameter int QUARTER_CYC = SCL_QUARTER_CYC
)
(
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // serial link
    serial_link_if.host      link,
    // axi4-lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    typedef struct packed {
        logic [2:0]  sda_sync;
        logic        sda_in;
        host_fsm_t   st;
        logic [1:0]  phase;
        logic [15:0] qcnt;
        logic [2:0]  bitn;
        logic [7:0]  shreg;
        logic [2:0]  byte_idx;
        logic [1:0]  ncfg;
        logic        scl_oe_n;
        logic        sda_oe_n;
        logic        busy;
        logic        nack;
        logic [23:0] cfg;
        logic [15:0] hdr;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  waddr;
        logic [31:0] wdat;
        logic [3:0]  wstb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } host_state_t;

    host_state_t s;
    host_state_t next_s;
    logic        go;
    logic        tick;
    logic [2:0]  last_idx;

    // byte n of the frame: address, command, count, then config bytes
    function automatic logic [7:0] frame_byte(input logic [2:0] idx,
                                              input logic [15:0] h,
                                              input logic [23:0] c);
        logic [7:0] b;
        b = c[23:16];
        unique case (idx)
            3'h0: b = DEV_ADDR_WRITE;
            3'h1: b = h[7:0];
            3'h2: b = h[15:8];
            3'h3: b = c[7:0];
            3'h4: b = c[15:8];
            default: b = c[23:16];
        endcase
        return b;
    endfunction

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] stb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (stb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        next_s = s;
        go     = 1'b0;

        // data line comes back from the far end: three stages, agree on two
        next_s.sda_sync = {s.sda_sync[1:0], link.sda};
        if (s.sda_sync[1] == s.sda_sync[2]) begin
            next_s.sda_in = s.sda_sync[1];
        end

        // write channel: address and data in either order
        if (awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.waddr  = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdat  = wdata;
            next_s.wstb  = wstrb;
        end
        if (bready && s.bvalid) begin
            next_s.bvalid = 1'b0;
        end
        if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_OKAY;
            unique case (next_s.waddr)
                REG_CTRL: begin
                    // go is ignored while a frame is on the wire
                    go = next_s.wstb[0] && next_s.wdat[CTRL_GO_BIT] && !s.busy;
                    if (go) begin
                        next_s.ncfg = next_s.wdat[CTRL_NCFG_LSB +: 2];
                    end
                end
                REG_STATUS: ;
                REG_CFG: next_s.cfg = 24'(merge({8'h00, s.cfg}, next_s.wdat, next_s.wstb));
                REG_HDR: next_s.hdr = 16'(merge({16'h0, s.hdr}, next_s.wdat, next_s.wstb));
                default: next_s.bresp = RESP_SLVERR;
            endcase
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;

        // read channel
        if (rready && s.rvalid) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            unique case (araddr)
                REG_CTRL:   next_s.rdata = {29'h0, s.ncfg, 1'b0};
                REG_STATUS: next_s.rdata = {30'h0, s.nack, s.busy};
                REG_CFG:    next_s.rdata = {8'h00, s.cfg};
                REG_HDR:    next_s.rdata = {16'h0, s.hdr};
                default: begin
                    next_s.rdata = 32'h0;
                    next_s.rresp = RESP_SLVERR;
                end
            endcase
        end
        next_s.arready = !next_s.rvalid;

        // quarter-bit timebase for the serial clock divider
        tick     = (s.qcnt == 16'h0);
        last_idx = HDR_BYTES - 3'h1 + {1'b0, s.ncfg};
        if (s.st == H_IDLE || tick) begin
            next_s.qcnt = 16'(QUARTER_CYC - 1);
        end else begin
            next_s.qcnt = s.qcnt - 16'h1;
        end
        if (tick && s.st != H_IDLE) begin
            next_s.phase = s.phase + 2'h1;
        end

        unique case (s.st)
            H_IDLE: begin
                if (go) begin
                    next_s.st       = H_START;
                    next_s.phase    = 2'h0;
                    next_s.busy     = 1'b1;
                    next_s.nack     = 1'b0;
                    next_s.byte_idx = 3'h0;
                end
            end
            H_START: if (tick) begin
                // data falls while clock is high, then clock drops
                if (s.phase == 2'h1) next_s.sda_oe_n = 1'b0;
                if (s.phase == 2'h2) next_s.scl_oe_n = 1'b0;
                if (s.phase == 2'h3) begin
                    next_s.st    = H_BIT;
                    next_s.shreg = frame_byte(3'h0, s.hdr, s.cfg);
                    next_s.bitn  = 3'h7;
                end
            end
            H_BIT: if (tick) begin
                // data moves only in phase 0, clock low
                if (s.phase == 2'h0) next_s.sda_oe_n = s.shreg[7];
                if (s.phase == 2'h1) next_s.scl_oe_n = 1'b1;
                if (s.phase == 2'h3) begin
                    next_s.scl_oe_n = 1'b0;
                    next_s.shreg    = {s.shreg[6:0], 1'b0};
                    next_s.bitn     = s.bitn - 3'h1;
                    if (s.bitn == 3'h0) next_s.st = H_ACK;
                end
            end
            H_ACK: if (tick) begin
                if (s.phase == 2'h0) next_s.sda_oe_n = 1'b1;
                if (s.phase == 2'h1) next_s.scl_oe_n = 1'b1;
                if (s.phase == 2'h2) next_s.nack = s.sda_in;
                if (s.phase == 2'h3) begin
                    next_s.scl_oe_n = 1'b0;
                    if (s.nack || s.byte_idx == last_idx) begin
                        next_s.st = H_STOP;
                    end else begin
                        // the next byte of the frame follows, in order
                        next_s.st       = H_BIT;
                        next_s.byte_idx = s.byte_idx + 3'h1;
                        next_s.shreg    = frame_byte(s.byte_idx + 3'h1, s.hdr, s.cfg);
                        next_s.bitn     = 3'h7;
                    end
                end
            end
            H_STOP: if (tick) begin
                // data rises while clock is high
                if (s.phase == 2'h0) next_s.sda_oe_n = 1'b0;
                if (s.phase == 2'h1) next_s.scl_oe_n = 1'b1;
                if (s.phase == 2'h2) next_s.sda_oe_n = 1'b1;
                if (s.phase == 2'h3) begin
                    next_s.st   = H_IDLE;
                    next_s.busy = 1'b0;
                end
            end
            default: next_s.st = H_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s          <= '0;
            s.st       <= H_IDLE;
            s.sda_sync <= 3'h7;
            s.sda_in   <= 1'b1;
            s.scl_oe_n <= 1'b1;
            s.sda_oe_n <= 1'b1;
            s.cfg      <= HOST_CFG_RESET;
            s.hdr      <= HOST_HDR_RESET;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // open-drain: value is always low, enable low pulls
    assign link.host_scl_o    = 1'b0;
    assign link.host_sda_o    = 1'b0;
    assign link.host_scl_oe_n = s.scl_oe_n;
    assign link.host_sda_oe_n = s.sda_oe_n;
    assign awready = s.awready;
    assign wready  = s.wready;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign arready = s.arready;
    assign rvalid  = s.rvalid;
    assign rdata   = s.rdata;
    assign rresp   = s.rresp;

endmodule

// ---- clk_fanout_pkg.sv ----
// shared constants and types for the clock fan-out control link
package clk_fanout_pkg;
    // fan-out geometry
    localparam int          NUM_OUTPUTS    = 18;
    localparam logic [17:0] CFG_RESET      = 18'h3ffff;
    localparam int          HIGH_BIT_OUT17 = 7;
    localparam int          HIGH_BIT_OUT16 = 6;

    // serial framing
    localparam logic [7:0]  DEV_ADDR_WRITE = 8'hd2;
    localparam logic [2:0]  HDR_BYTES      = 3'h3;
    localparam logic [2:0]  LAST_BYTE_IDX  = 3'h6;
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;

    // synchroniser lanes and their idle levels
    localparam int          IN_SCL         = 0;
    localparam int          IN_SDA         = 1;
    localparam int          IN_BUF         = 2;
    localparam int          IN_OE          = 3;
    localparam logic [3:0]  SYNC_RESET     = 4'hb;

    // host timing
    localparam int          CLK_PERIOD_PS  = 5000;
    localparam int          SCL_QUARTER_NS = 125;
    localparam int          SCL_QUARTER_CYC =
        (SCL_QUARTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // host register map
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_CFG        = 8'h08;
    localparam logic [7:0]  REG_HDR        = 8'h0c;
    localparam int          CTRL_GO_BIT    = 0;
    localparam int          CTRL_NCFG_LSB  = 1;
    localparam int          STATUS_BUSY_BIT = 0;
    localparam int          STATUS_NACK_BIT = 1;
    localparam logic [23:0] HOST_CFG_RESET = 24'hffffff;
    localparam logic [15:0] HOST_HDR_RESET = 16'h0000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {D_IDLE, D_RECV, D_ACK} dev_fsm_t;
    typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_ACK, H_STOP} host_fsm_t;
endpackage

// ---- serial_link_if.sv ----
// two-wire serial link joining the host end and the device end
`timescale 1ns/1ps
interface serial_link_if;
    // open-drain drivers, enable low while pulling
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    // resolved wire levels, pulled up when nobody drives
    logic scl;
    logic sda;

    assign scl = host_scl_oe_n | host_scl_o;
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

    modport device (
        input  scl,
        input  sda,
        output dev_sda_o,
        output dev_sda_oe_n
    );

    modport host (
        input  scl,
        input  sda,
        output host_scl_o,
        output host_scl_oe_n,
        output host_sda_o,
        output host_sda_oe_n
    );
endinterface

// ---- clock_fanout_device.sv ----
// device end: serial configuration slave and 18-way clock fan-out
`timescale 1ns/1ps
module clock_fanout_device
    import clk_fanout_pkg::*;
(
    // clock, reset, enable
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   ce,
    // serial link
    serial_link_if.device               link,
    // fan-out side
    input  wire logic                   buf_in,
    input  wire logic                   out_en,
    output logic [NUM_OUTPUTS-1:0]      clk_out,
    output logic [NUM_OUTPUTS-1:0]      clk_out_oe_n
);

    typedef struct packed {
        logic [3:0]             sync1;
        logic [3:0]             sync2;
        logic [3:0]             sync3;
        logic [3:0]             stable;
        dev_fsm_t               st;
        logic [3:0]             bitcnt;
        logic [7:0]             shreg;
        logic [2:0]             byte_idx;
        logic                   sda_oe_n;
        logic [NUM_OUTPUTS-1:0] cfg;
        logic [NUM_OUTPUTS-1:0] clk_q;
        logic [NUM_OUTPUTS-1:0] oe_n_q;
    } dev_state_t;

    dev_state_t s;
    dev_state_t next_s;

    logic [3:0] agree;
    logic       scl_prev;
    logic       scl_now;
    logic       sda_prev;
    logic       sda_now;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;

    // reset state: every output enabled, serial side idle
    localparam dev_state_t DEV_RESET = '{
        sync1:    SYNC_RESET,
        sync2:    SYNC_RESET,
        sync3:    SYNC_RESET,
        stable:   SYNC_RESET,
        st:       D_IDLE,
        bitcnt:   4'h0,
        shreg:    8'h00,
        byte_idx: 3'h0,
        sda_oe_n: 1'b1,
        cfg:      CFG_RESET,
        clk_q:    {NUM_OUTPUTS{1'b0}},
        oe_n_q:   {NUM_OUTPUTS{1'b0}}
    };

    // all next-state logic in one place
    always_comb begin
        next_s = s;

        // three-stage synchronisers; a level counts once stages two and three agree
        next_s.sync1  = {out_en, buf_in, link.sda, link.scl};
        next_s.sync2  = s.sync1;
        next_s.sync3  = s.sync2;
        agree         = ~(s.sync2 ^ s.sync3);
        next_s.stable = (s.stable & ~agree) | (s.sync2 & agree);

        // edges on the filtered link levels
        scl_prev   = s.stable[IN_SCL];
        scl_now    = next_s.stable[IN_SCL];
        sda_prev   = s.stable[IN_SDA];
        sda_now    = next_s.stable[IN_SDA];
        scl_rise   = !scl_prev && scl_now;
        scl_fall   = scl_prev && !scl_now;
        // data moving under a high clock is framing, never a data bit
        start_seen = scl_prev && scl_now && sda_prev && !sda_now;
        stop_seen  = scl_prev && scl_now && !sda_prev && sda_now;

        if (stop_seen) begin
            // stop ends the transfer and frees the data line
            next_s.st       = D_IDLE;
            next_s.sda_oe_n = 1'b1;
        end else if (start_seen) begin
            // a start, repeated or not, restarts at the address byte
            next_s.st       = D_RECV;
            next_s.bitcnt   = 4'h0;
            next_s.byte_idx = 3'h0;
            next_s.sda_oe_n = 1'b1;
        end else begin
            unique case (s.st)
                D_IDLE: begin
                    next_s.sda_oe_n = 1'b1;
                end

                D_RECV: begin
                    if (scl_rise && s.bitcnt != BITS_PER_BYTE) begin
                        // msb arrives first
                        next_s.shreg  = {s.shreg[6:0], sda_now};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (scl_fall && s.bitcnt == BITS_PER_BYTE) begin
                        if (s.byte_idx == 3'h0 && s.shreg != DEV_ADDR_WRITE) begin
                            // foreign address or a read: stay off the bus
                            next_s.st = D_IDLE;
                        end else begin
                            // pull data low across the ninth clock
                            next_s.sda_oe_n = 1'b0;
                            next_s.st       = D_ACK;
                            unique case (s.byte_idx)
                                HDR_BYTES: begin
                                    next_s.cfg[7:0] = s.shreg;
                                end
                                HDR_BYTES + 3'h1: begin
                                    next_s.cfg[15:8] = s.shreg;
                                end
                                HDR_BYTES + 3'h2: begin
                                    // bits 5..0 are reserved and dropped
                                    next_s.cfg[17] = s.shreg[HIGH_BIT_OUT17];
                                    next_s.cfg[16] = s.shreg[HIGH_BIT_OUT16];
                                end
                                default: begin
                                    // address, command and count bytes carry nothing
                                    next_s.cfg = s.cfg;
                                end
                            endcase
                        end
                    end
                end

                D_ACK: begin
                    // release after the ninth clock, then take the next byte
                    if (scl_fall) begin
                        next_s.sda_oe_n = 1'b1;
                        next_s.st       = D_RECV;
                        next_s.bitcnt   = 4'h0;
                        if (s.byte_idx != LAST_BYTE_IDX) begin
                            // saturate: extra bytes are acked and ignored
                            next_s.byte_idx = s.byte_idx + 3'h1;
                        end
                    end
                end

                default: begin
                    next_s.st = D_IDLE;
                end
            endcase
        end

        // fan-out: disabled outputs sit low, enable pin low floats all
        next_s.clk_q  = s.cfg & {NUM_OUTPUTS{next_s.stable[IN_BUF]}};
        next_s.oe_n_q = {NUM_OUTPUTS{~next_s.stable[IN_OE]}};
    end

    // the single state register; ce low freezes everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= DEV_RESET;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // the device never pulls the line high
    assign link.dev_sda_o    = 1'b0;
    assign link.dev_sda_oe_n = s.sda_oe_n;

    // outputs straight from the state register
    assign clk_out      = s.clk_q;
    assign clk_out_oe_n = s.oe_n_q;

endmodule

// ---- clock_fanout_monitor.sv ----
// wire-level checks on the serial link between the host and device ends
`timescale 1ns/1ps
module clock_fanout_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link signals
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_oe_n
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_cnt;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // clock rises counted modulo nine, cleared by a start
    always_ff @(posedge aclk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (!aresetn || (scl && scl_q && sda_q && !sda)) begin
            bit_cnt <= 4'h0;
        end else if (scl && !scl_q) begin
            bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
        end
    end

    a_ack_ninth: assert property ($fell(dev_sda_oe_n) |-> bit_cnt == 4'h8)
        else $error("ack pull not after eighth bit");
    a_release_ninth: assert property ($rose(dev_sda_oe_n) |-> bit_cnt == 4'h0)
        else $error("ack release not after ninth pulse");
    a_ack_held: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
        else $error("ack pull too short");
    a_ack_ends: assert property ($fell(dev_sda_oe_n) |-> ##[8:120] $rose(dev_sda_oe_n))
        else $error("ack pull never released");
    a_no_clash: assert property (!dev_sda_oe_n && scl |-> host_sda_oe_n)
        else $error("both ends pull data with clock high");
    a_start_clock: assert property ($fell(sda) && scl && $past(scl) |-> ##[1:40] !scl)
        else $error("no clock low after start");
    a_stop_idle: assert property ($rose(sda) && scl && $past(scl) |-> scl [*8])
        else $error("clock not idle after stop");
    a_addr_acked: assert property ($fell(sda) && scl && $past(scl) |->
        ##[1:400] $fell(dev_sda_oe_n))
        else $error("address byte not acknowledged");
endmodule

// ---- clock_fanout_output_control_bench.sv ----
// self-checking bench joining host and device ends over the serial link
`timescale 1ns/1ps
module clock_fanout_output_control_bench
    import clk_fanout_pkg::*;
;
    // clock, reset and fan-out pins
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        buf_in = 1'b0;
    logic        out_en = 1'b1;
    logic        ce = 1'b1;
    logic [17:0] clk_out;
    logic [17:0] clk_out_oe_n;
    // axi4-lite
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    // bench state
    logic [31:0] rd;
    logic [1:0]  rs;
    logic [23:0] cur = 24'hffffff;
    int          miscompares = 0;
    int          samples_checked = 0;

    always #2.5 aclk = ~aclk;

    serial_link_if link ();
    clock_fanout_device i_clock_fanout_device (.aclk, .aresetn, .ce, .link(link.device),
        .buf_in, .out_en, .clk_out, .clk_out_oe_n);
    // short quarters keep frames brief yet above the device filter lag
    clock_fanout_host #(.QUARTER_CYC(6)) i_clock_fanout_host (.aclk, .aresetn, .ce,
        .link(link.host), .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);
    clock_fanout_monitor i_clock_fanout_monitor (.aclk, .aresetn, .scl(link.scl),
        .sda(link.sda), .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("compares=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic hang();
        miscompares++;
        conclude();
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        rs = bresp;
        if (n == 100) hang();
    endtask

    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
        if (n == 100) hang();
    endtask

    // pulse the input clock high then low and compare every output
    task automatic look();
        @(posedge aclk);
        buf_in <= 1'b1;
        repeat (10) @(posedge aclk);
        chk({14'h0, clk_out}, {14'h0, cur[23], cur[22], cur[15:0]});
        chk({14'h0, clk_out_oe_n}, 32'h0);
        buf_in <= 1'b0;
        repeat (10) @(posedge aclk);
        chk({14'h0, clk_out}, 32'h0);
    endtask

    // send n config bytes of c; earlier bytes are resent, later ones kept
    task automatic frame(input logic [23:0] c, input logic [1:0] n);
        int k;
        axw(REG_CFG, {8'h00, c});
        axw(REG_CTRL, {29'h0, n, 1'b1});
        for (k = 0; k < 2000; k++) begin
            axr(REG_STATUS);
            if (rd[STATUS_BUSY_BIT] === 1'b0) break;
        end
        if (k == 2000) hang();
        chk(rd, 32'h0);
        for (k = 0; k < n; k++) cur[8*k+:8] = c[8*k+:8];
        look();
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        look();
        axr(REG_CFG);
        chk(rd, 32'h00ffffff);
        axr(8'h10);
        chk({30'h0, rs}, 32'h2);
        axw(8'h14, 32'h1);
        chk({30'h0, rs}, 32'h2);
        axw(REG_HDR, 32'h0000a55a);
        axr(REG_HDR);
        chk(rd, 32'h0000a55a);
        frame(24'h7f3cc3, 2'h3);
        frame(24'h000000, 2'h1);
        frame(24'h000000, 2'h0);
        frame(24'hffffff, 2'h2);
        // enable low must freeze the fan-out at its last (low) level
        @(posedge aclk);
        ce     <= 1'b0;
        buf_in <= 1'b1;
        repeat (10) @(posedge aclk);
        chk({14'h0, clk_out}, 32'h0);
        ce     <= 1'b1;
        repeat (10) @(posedge aclk);
        chk({14'h0, clk_out}, {14'h0, cur[23], cur[22], cur[15:0]});
        @(posedge aclk);
        out_en <= 1'b0;
        buf_in <= 1'b1;
        repeat (10) @(posedge aclk);
        chk({14'h0, clk_out_oe_n}, 32'h3ffff);
        conclude();
    end
endmodule
